// file: common/add_sub_consts.vh
// Constants for the signed add/subtract unit: register offsets, fields,
// reset values and the operation-cycle timing.
// Assumes inclusion by bare name from the design files under verilog/.
`ifndef ADD_SUB_CONSTS_VH
`define ADD_SUB_CONSTS_VH

// Timing: reference clock and operation cycle
`define REF_CLK_NS        40
`define OP_CYCLE_NS       1000
`define OP_CYCLE_CYC      (`OP_CYCLE_NS / `REF_CLK_NS)

// Register offsets (word addresses on the plain register port)
`define OFS_CONTROL       8'h00
`define OFS_CONST1_LO     8'h01
`define OFS_CONST1_HI     8'h02
`define OFS_CONST2_LO     8'h03
`define OFS_CONST2_HI     8'h04
`define OFS_STATUS        8'h05
`define OFS_INDEX         8'h06
`define OFS_WORD_BASE     8'h10
`define OFS_WORD_MASK     8'hf0

// Operation codes
`define OP_SUM            2'h0
`define OP_DIFFERENCE     2'h1
`define OP_STEP_UP        2'h2

// Control register fields
`define CTL_OP_LSB        0
`define CTL_OP_MSB        1
`define CTL_WIDE          2
`define CTL_PULSE         3
`define CTL_S1_CONST      4
`define CTL_S2_CONST      5
`define CTL_ENABLE        6
`define CTL_RESET         16'h0000

// Index register fields
`define IDX_S1_LSB        0
`define IDX_S1_MSB        3
`define IDX_S2_LSB        4
`define IDX_S2_MSB        7
`define IDX_DST_LSB       8
`define IDX_DST_MSB       11
`define IDX_RESET         16'h0000

// Status register fields
`define STS_ZERO          0
`define STS_BORROW        1
`define STS_CARRY         2
`define STS_CMD_LAST      3
`define STS_COUNT_LSB     8
`define STS_COUNT_MSB     15

// Word store and constant reset values
`define WORD_RESET        16'h0000
`define NUM_WORDS         16

`endif

// file: verilog/add_sub_core.v
// Combinational signed add/subtract/step-up core with range flags.
// Assumes operands arrive as 32 bits; in 16-bit mode only the low half
// is looked at and sign-extended.
`timescale 1ns/1ps
`default_nettype none
`include "add_sub_consts.vh"

module add_sub_core
(
	// Operation select
	input  wire [1:0]  op,
	input  wire        wide,
	// Operands
	input  wire [31:0] opd_a,
	input  wire [31:0] opd_b,
	// Result and flags
	output reg  [31:0] result,
	output reg         zero,
	output reg         borrow,
	output reg         carry
);

	// Operands widened so the true result never wraps
	wire signed [33:0] a_x;
	wire signed [33:0] b_x;
	// Limits of the selected width
	wire signed [33:0] lim_max;
	wire signed [33:0] lim_min;
	// True, unwrapped result
	reg  signed [33:0] raw;
	reg  signed [33:0] fixed;

	// Sign bit is the top bit of each operand
	assign a_x = wide ? {{2{opd_a[31]}}, opd_a}
	                  : {{18{opd_a[15]}}, opd_a[15:0]};              // see RULE4
	assign b_x = wide ? {{2{opd_b[31]}}, opd_b}
	                  : {{18{opd_b[15]}}, opd_b[15:0]};              // see RULE4
	assign lim_max = wide ? 34'sh0_7fff_ffff : 34'sh0_0000_7fff;
	assign lim_min = wide ? 34'sh3_8000_0000 : 34'sh3_ffff_8000;

	// Arithmetic, then fold an out-of-range result back to zero onward
	always @*
	begin
		case (op)
			`OP_SUM:        raw = a_x + b_x;                             // see RULE1
			`OP_DIFFERENCE: raw = a_x - b_x;                        // see RULE2
			`OP_STEP_UP:    raw = a_x + 34'sh0_0000_0001;
			default:        raw = a_x;
		endcase
		carry  = 1'b0;
		borrow = 1'b0;
		fixed  = raw;
		// Step-up simply wraps: low bits of raw already hold the wrap
		if (op != `OP_STEP_UP)
		begin
			if (raw > lim_max)
			begin
				carry = 1'b1;                                        // see RULE16
				fixed = raw - lim_max - 34'sh0_0000_0001;   // see RULE12 RULE13
			end
			else if (raw < lim_min)
			begin
				borrow = 1'b1;                                       // see RULE15
				fixed = raw - lim_min + 34'sh0_0000_0001;   // see RULE12 RULE13
			end
		end
		result = wide ? fixed[31:0] : {16'h0000, fixed[15:0]};
		zero   = wide ? (fixed[31:0] == 32'h0000_0000)
		              : (fixed[15:0] == 16'h0000);                  // see RULE14
	end

endmodule // add_sub_core

`default_nettype wire

// file: verilog/signed_add_sub_unit.v
// Signed add/subtract unit with its own word store, operand constants and
// zero/borrow/carry flags, executed at most once per operation cycle.
// Assumes the sequencer drives command_input synchronous to ref_clk and
// software sets up operands over the plain register port.
//
// Functional notes
// RULE1: Sum writes first plus second source
// RULE2: 16-bit difference writes first minus second
// RULE3: 32-bit difference uses consecutive word pairs
// RULE4: Top bit is sign, arithmetic is algebraic
// RULE5: Constants enter arithmetic as binary values
// RULE6: Low word at index, high next
// RULE7: Issuer should use even starting words
// RULE8: Destination may equal a source word
// RULE9: Continuous forms run each cycle while on
// RULE10: Pulse forms run once per rising command
// RULE11: Add/subtract update flags, step-up does not
// RULE12: 16-bit overflow folds to zero, step-up wraps
// RULE13: 32-bit overflow folds to zero, step-up wraps
// RULE14: Zero flag follows result equal zero
// RULE15: Borrow flag marks result below minimum
// RULE16: Carry flag marks result above maximum
// RULE17: Destination must be a word, not constant
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "add_sub_consts.vh"

module signed_add_sub_unit
(
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst_b,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata_q,
	// Sequencer command
	input  wire        command_input,
	// Flags and execution marker
	output reg         zero_flag_q,
	output reg         borrow_flag_q,
	output reg         carry_flag_q,
	output reg         exec_done_q
);

	// Operation-cycle divider
	reg  [7:0]  cyc_cnt_q;                 // Counts clocks in one cycle
	reg  [7:0]  cyc_cnt_d;
	reg         op_tick_q;                 // One-cycle operation enable
	wire        op_tick_d;

	// Software-visible setup
	reg  [15:0] control_q;                 // Operation, width, form
	reg  [15:0] index_q;                   // Source and destination words
	reg  [15:0] const1_lo_q;               // First constant, low word
	reg  [15:0] const1_hi_q;               // First constant, high word
	reg  [15:0] const2_lo_q;               // Second constant, low word
	reg  [15:0] const2_hi_q;               // Second constant, high word

	// Word store: the destinations and word-valued sources
	reg  [15:0] words_q [0:`NUM_WORDS-1];

	// Command history and execution count
	reg         cmd_last_q;                // Command level at last tick
	reg  [7:0]  exec_cnt_q;                // Executions, wraps at 255

	// Decoded control fields
	wire [1:0]  op_sel;
	wire        wide;
	wire        pulse_form;
	wire        s1_const;
	wire        s2_const;
	wire        run_en;
	wire [3:0]  s1_idx;
	wire [3:0]  s2_idx;
	wire [3:0]  dst_idx;
	wire [3:0]  s1_idx_hi;
	wire [3:0]  s2_idx_hi;
	wire [3:0]  dst_idx_hi;

	// Operands and results
	wire [31:0] src1_val;
	wire [31:0] src2_val;
	wire [31:0] res_val;
	wire        res_zero;
	wire        res_borrow;
	wire        res_carry;
	wire        fire;

	// Bus decode
	wire        word_hit;
	wire [3:0]  word_sel;
	reg  [15:0] rd_mux;
	integer     i;

	assign op_sel     = control_q[`CTL_OP_MSB:`CTL_OP_LSB];
	assign wide       = control_q[`CTL_WIDE];
	assign pulse_form = control_q[`CTL_PULSE];
	assign s1_const   = control_q[`CTL_S1_CONST];
	assign s2_const   = control_q[`CTL_S2_CONST];
	assign run_en     = control_q[`CTL_ENABLE];
	assign s1_idx     = index_q[`IDX_S1_MSB:`IDX_S1_LSB];
	assign s2_idx     = index_q[`IDX_S2_MSB:`IDX_S2_LSB];
	assign dst_idx    = index_q[`IDX_DST_MSB:`IDX_DST_LSB];

	// The high word sits at the next word number, wrapping in the store
	// Odd or top starting words may overlap another pair; the issuer
	// is expected to pick even words so that pairs stay apart
	assign s1_idx_hi  = s1_idx + 4'h1;                               // see RULE6
	assign s2_idx_hi  = s2_idx + 4'h1;                               // see RULE6
	assign dst_idx_hi = dst_idx + 4'h1;                              // see RULE6

	// Sources read the store live, so a shared destination feeds back
	assign src1_val = s1_const ? {const1_hi_q, const1_lo_q}          // see RULE5
	                           : {words_q[s1_idx_hi], words_q[s1_idx]}; // see RULE8
	assign src2_val = s2_const ? {const2_hi_q, const2_lo_q}          // see RULE5
	                           : {words_q[s2_idx_hi], words_q[s2_idx]}; // see RULE3

	// Continuous form runs on every tick the command is on; pulse form
	// only on the tick that first sees it on
	// The edge is judged tick to tick, so a command pulse shorter than
	// one operation cycle can be missed entirely
	assign fire = op_tick_q & run_en & command_input &
	              (~pulse_form | ~cmd_last_q);               // see RULE9 RULE10

	// Arithmetic core
	add_sub_core u_core
	(
		.op     (op_sel),
		.wide   (wide),
		.opd_a  (src1_val),
		.opd_b  (src2_val),
		.result (res_val),
		.zero   (res_zero),
		.borrow (res_borrow),
		.carry  (res_carry)
	);

	// Divider: one enable per operation cycle
	// Free-running, so its phase is not tied to the command; inputs are
	// seen once per operation cycle, as on a scan-cycle controller
	always @*
	begin
		if (cyc_cnt_q == (`OP_CYCLE_CYC - 1))
			cyc_cnt_d = 8'h00;
		else
			cyc_cnt_d = cyc_cnt_q + 8'h01;
	end
	assign op_tick_d = (cyc_cnt_q == (`OP_CYCLE_CYC - 1));

	// Divider registers
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cyc_cnt_q <= 8'h00;
			op_tick_q <= 1'b0;
		end
		else
		begin
			cyc_cnt_q <= cyc_cnt_d;
			op_tick_q <= op_tick_d;
		end
	end

	// Command level remembered once per tick, for edge detection
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			cmd_last_q <= 1'b0;
		else if (op_tick_q)
			cmd_last_q <= command_input;                             // see RULE10
	end

	// Setup registers written by software
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			control_q   <= `CTL_RESET;
			index_q     <= `IDX_RESET;
			const1_lo_q <= `WORD_RESET;
			const1_hi_q <= `WORD_RESET;
			const2_lo_q <= `WORD_RESET;
			const2_hi_q <= `WORD_RESET;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`OFS_CONTROL:   control_q   <= reg_wdata;
				`OFS_INDEX:     index_q     <= reg_wdata;
				`OFS_CONST1_LO: const1_lo_q <= reg_wdata;
				`OFS_CONST1_HI: const1_hi_q <= reg_wdata;
				`OFS_CONST2_LO: const2_lo_q <= reg_wdata;
				`OFS_CONST2_HI: const2_hi_q <= reg_wdata;
				default:        ;                 // Status and store elsewhere
			endcase
		end
	end

	assign word_hit = ((reg_addr & `OFS_WORD_MASK) == `OFS_WORD_BASE);
	assign word_sel = reg_addr[3:0];

	// Word store: software writes first, so an execution in the same
	// cycle to the same word wins and no result is lost
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (i = 0; i < `NUM_WORDS; i = i + 1)
				words_q[i] <= `WORD_RESET;
		end
		else
		begin
			if (reg_wr && word_hit)
				words_q[word_sel] <= reg_wdata;
			if (fire)
			begin
				// Low word always; high word only in 32-bit mode
				words_q[dst_idx] <= res_val[15:0];               // see RULE1 RULE2
				if (wide)
					words_q[dst_idx_hi] <= res_val[31:16];           // see RULE3
			end
		end
	end

	// Flags: add and subtract refresh all three, step-up leaves them
	// Software cannot clear them; only an execution moves them
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			zero_flag_q   <= 1'b0;
			borrow_flag_q <= 1'b0;
			carry_flag_q  <= 1'b0;
		end
		else if (fire && (op_sel != `OP_STEP_UP))                   // see RULE11
		begin
			zero_flag_q   <= res_zero;                              // see RULE14
			borrow_flag_q <= res_borrow;                            // see RULE15
			carry_flag_q  <= res_carry;                             // see RULE16
		end
	end

	// Execution marker and count
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			exec_done_q <= 1'b0;
			exec_cnt_q  <= 8'h00;
		end
		else
		begin
			exec_done_q <= fire;
			if (fire)
				exec_cnt_q <= exec_cnt_q + 8'h01;
		end
	end

	// Read mux; unmapped addresses read as zero
	// Status is built bit by bit so its spare bits stay zero
	always @*
	begin
		rd_mux = 16'h0000;
		if (word_hit)
			rd_mux = words_q[word_sel];
		else
		begin
			case (reg_addr)
				`OFS_CONTROL:   rd_mux = control_q;
				`OFS_INDEX:     rd_mux = index_q;
				`OFS_CONST1_LO: rd_mux = const1_lo_q;
				`OFS_CONST1_HI: rd_mux = const1_hi_q;
				`OFS_CONST2_LO: rd_mux = const2_lo_q;
				`OFS_CONST2_HI: rd_mux = const2_hi_q;
				`OFS_STATUS:
				begin
					rd_mux[`STS_ZERO]     = zero_flag_q;
					rd_mux[`STS_BORROW]   = borrow_flag_q;
					rd_mux[`STS_CARRY]    = carry_flag_q;
					rd_mux[`STS_CMD_LAST] = cmd_last_q;
					rd_mux[`STS_COUNT_MSB:`STS_COUNT_LSB] = exec_cnt_q;
				end
				default:        rd_mux = 16'h0000;
			endcase
		end
	end

	// Read data held only in the cycle after the strobe
	// Zeroing between reads keeps stale data off the port, so a master
	// that samples late sees zero rather than an old value
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata_q <= 16'h0000;
		else if (reg_rd)
			reg_rdata_q <= rd_mux;
		else
			reg_rdata_q <= 16'h0000;
	end

endmodule // signed_add_sub_unit

`default_nettype wire

// file: verification/add_sub_checker_asserts.sv
// Port checker for the signed add/subtract unit.
// Assumes one clock, async active-low reset, bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module add_sub_checker
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_b,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata_q,
	// Command and flags
	input wire logic        command_input,
	input wire logic        zero_flag_q,
	input wire logic        borrow_flag_q,
	input wire logic        carry_flag_q,
	input wire logic        exec_done_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	logic [7:0] gap_q;                 // Cycles since last execution
	wire  [2:0] flags = {zero_flag_q, borrow_flag_q, carry_flag_q};
	// Saturating gap counter; starts high so the first run is legal
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			gap_q <= 8'hff;
		else if (exec_done_q)
			gap_q <= 8'h00;
		else if (gap_q != 8'hff)
			gap_q <= gap_q + 8'h01;
	sequence flag_move;
		$changed(flags);
	endsequence
	// Flags and marker are launched by the same firing edge, so they
	// are seen together in one sample
	sequence done_seen;
		exec_done_q;
	endsequence
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
		else $error("read data outside its slot");
	reset_quiet_a: assert property ($rose(rst_b) |-> !exec_done_q && flags == 3'h0)
		else $error("outputs busy right after reset");
	flags_move_a: assert property (flag_move |-> done_seen)
		else $error("flags moved without an execution");
	flags_hold_a: assert property (exec_done_q |=> $stable(flags) [*3])
		else $error("flags moved after an execution");
	done_single_a: assert property (exec_done_q |=> !exec_done_q)
		else $error("execution marker longer than a cycle");
	done_gap_a: assert property (exec_done_q |-> gap_q >= 8'h18)
		else $error("two executions in one operation cycle");
	done_cmd_a: assert property (exec_done_q |-> $past(command_input))
		else $error("execution without command");
	flag_excl_a: assert property (!(borrow_flag_q && carry_flag_q))
		else $error("borrow and carry together");
endmodule // add_sub_checker
bind signed_add_sub_unit add_sub_checker chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_q(reg_rdata_q), .command_input(command_input),
	.zero_flag_q(zero_flag_q), .borrow_flag_q(borrow_flag_q),
	.carry_flag_q(carry_flag_q), .exec_done_q(exec_done_q));
`default_nettype wire

// file: verification/seq_model.sv
// Sequencer model: holds the command condition for a span of clocks.
// Assumes the unit ticks every 25 clocks at a phase it cannot see.
`timescale 1ns/1ps
`default_nettype none
module seq_model
(
	// Clock
	input  wire logic ref_clk,
	// Unit side
	input  wire logic exec_done_q,
	output var  logic command_input
);
	initial command_input = 1'b0;
	// Hold command, then keep it low over a full tick, counting runs
	task automatic press(input int span, output int n);
		n = 0;
		command_input <= 1'b1;
		repeat (span)
		begin
			@(posedge ref_clk);
			n += exec_done_q;
		end
		command_input <= 1'b0; // Low tick re-arms pulse forms
		repeat (27)
		begin
			@(posedge ref_clk);
			n += exec_done_q;
		end
	endtask
endmodule // seq_model
`default_nettype wire

// file: verification/signed_add_sub_unit_tb_top.sv
// Self-checking bench for the signed add/subtract unit.
// Assumes the unit's constants header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "add_sub_consts.vh"
module signed_add_sub_unit_tb_top;
	logic        ref_clk = 1'b0;      // 25 MHz
	logic        rst_b = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	wire  [15:0] reg_rdata_q;
	wire         command_input, zero_flag_q, borrow_flag_q, carry_flag_q, exec_done_q;
	int          fails = 0;
	int          comparisons = 0;
	int          n;                   // Executions per press
	logic [15:0] exp_q[$];            // Expected read data
	logic [15:0] msk_q[$];            // Bits that matter
	logic [2:0]  flg_q[$];            // Expected {zero,borrow,carry}
	logic        rd_seen = 1'b0;
	logic [2:0]  last_f = 3'h0;       // Flags of last add/subtract
	logic [34:0] res_w;               // Expected word-pair result
	logic [31:0] opa, opb;            // Word-pair operands
	// Corner cases {op, wide, first, second}
	logic [66:0] cs[11] = '{{2'h0, 1'b0, 32'h5, 32'hfff8},
		{2'h0, 1'b0, 32'h7fff, 32'h1}, {2'h0, 1'b0, 32'h7fff, 32'h2},
		{2'h1, 1'b0, 32'h8000, 32'h1}, {2'h1, 1'b0, 32'h8000, 32'h2},
		{2'h1, 1'b0, 32'h5, 32'hfff8}, {2'h0, 1'b1, 32'h157c, 32'hffffdea4},
		{2'h1, 1'b1, 32'h80000000, 32'h1}, {2'h0, 1'b1, 32'h7fffffff, 32'h1},
		{2'h2, 1'b0, 32'h7fff, 32'h0}, {2'h2, 1'b1, 32'h7fffffff, 32'h0}};
	always #20 ref_clk = ~ref_clk;
	signed_add_sub_unit dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .command_input(command_input),
		.zero_flag_q(zero_flag_q), .borrow_flag_q(borrow_flag_q),
		.carry_flag_q(carry_flag_q), .exec_done_q(exec_done_q));
	seq_model seq (.ref_clk(ref_clk), .exec_done_q(exec_done_q),
		.command_input(command_input));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want)
		begin
			fails++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	// Results land a cycle after the strobe; flags on each execution
	always @(posedge ref_clk)
	begin
		rd_seen <= reg_rd;
		if (rd_seen)
			check(reg_rdata_q & msk_q.pop_front(), exp_q.pop_front());
		if (exec_done_q)
			check({zero_flag_q, borrow_flag_q, carry_flag_q},
				flg_q.size() ? flg_q.pop_front() : 3'bxxx);
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		msk_q.push_back(m);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic idle();
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Expected {zero, borrow, carry, result}; out of range folds
	function automatic logic [34:0] calc(input logic [1:0] op, input logic w,
		input logic [31:0] a, input logic [31:0] b);
		longint x, y, t, mx;
		logic c, bo;
		mx = w ? 64'sh7fffffff : 64'sh7fff;
		x = w ? $signed(a) : $signed(a[15:0]);
		y = w ? $signed(b) : $signed(b[15:0]);
		if (op == `OP_STEP_UP)
			return {last_f, a + 32'h1}; // Wraps, flags kept
		t = (op == `OP_DIFFERENCE) ? x - y : x + y;
		c = t > mx;
		bo = t < -mx - 1;
		if (c)
			t = t - mx - 1;
		if (bo)
			t = t + mx + 2;
		return {t == 0, bo, c, t[31:0]};
	endfunction
	// Constant operands, result into word 2, and word 3 in 32-bit mode
	task automatic run(input logic [1:0] op, input logic w, input logic p,
		input logic [31:0] a, input logic [31:0] b);
		logic [34:0] r;
		r = calc(op, w, a, b);
		wr(`OFS_CONST1_LO, a[15:0]);
		wr(`OFS_CONST1_HI, a[31:16]);
		wr(`OFS_CONST2_LO, b[15:0]);
		wr(`OFS_CONST2_HI, b[31:16]);
		wr(`OFS_INDEX, 16'h0200); // Even destination word
		wr(`OFS_CONTROL, {12'h007, p, w, op});
		flg_q.push_back(r[34:32]);
		last_f = r[34:32];
		idle();
		seq.press(25, n);
		check(n, 1);
		rd(8'h12, 16'hffff, r[15:0]);
		if (w)
			rd(8'h13, 16'hffff, r[31:16]);
		rd(`OFS_STATUS, 16'h0007, {13'h0, r[32], r[33], r[34]});
	endtask
	task automatic end_of_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		void'($urandom(5794));
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		// Reset values and an unmapped place
		for (int i = 0; i < 7; i++)
			rd(i[7:0], 16'hffff, 16'h0000);
		rd(8'h1f, 16'hffff, 16'h0000);
		rd(8'h30, 16'hffff, 16'h0000);
		$display("test reset done");
		foreach (cs[i])
			run(cs[i][66:65], cs[i][64], i[0], cs[i][63:32], cs[i][31:0]);
		repeat (8)
			run(2'($urandom_range(2, 0)), 1'($urandom), 1'($urandom), $urandom, $urandom);
		$display("test arithmetic done");
		// Word-valued 32-bit difference: words 6/7 minus 8/9 into 10/11
		opa = $urandom;
		opb = $urandom;
		res_w = calc(`OP_DIFFERENCE, 1'b1, opa, opb);
		wr(8'h16, opa[15:0]);
		wr(8'h17, opa[31:16]);
		wr(8'h18, opb[15:0]);
		wr(8'h19, opb[31:16]);
		wr(`OFS_INDEX, 16'h0a86); // Even starting words
		wr(`OFS_CONTROL, 16'h0045);
		flg_q.push_back(res_w[34:32]);
		last_f = res_w[34:32];
		idle();
		seq.press(25, n);
		check(n, 1);
		rd(8'h1a, 16'hffff, res_w[15:0]);
		rd(8'h1b, 16'hffff, res_w[31:16]);
		$display("test word pairs done");
		// Word 4 accumulates 25 per execution
		wr(8'h14, 16'h000a);
		wr(`OFS_INDEX, 16'h0404);
		wr(`OFS_CONST2_LO, 16'h0019);
		wr(`OFS_CONTROL, 16'h0060);
		repeat (4) flg_q.push_back(3'h0);
		last_f = 3'h0;
		idle();
		seq.press(75, n);
		check(n, 3);
		wr(`OFS_CONTROL, 16'h0068);
		idle();
		seq.press(75, n);
		check(n, 1);
		rd(8'h14, 16'hffff, 16'h006e);
		$display("test accumulate done");
		// Disabled unit ignores command; status is read-only
		wr(`OFS_CONTROL, 16'h0020);
		wr(`OFS_STATUS, 16'hffff);
		idle();
		seq.press(25, n);
		check(n, 0);
		rd(`OFS_STATUS, 16'h0007, 16'h0000);
		idle();
		idle();
		$display("test disable done");
		end_of_test();
	end
endmodule // signed_add_sub_unit_tb_top
`default_nettype wire
